// ### verilog/dftm_top.sv
// trip manager top: fault capture, lost command action, trip reset and apb registers
// Function
// - lost action none: keep running when frequency command is lost
// - lost action free-run: remove drive, motor coasts to stop
// - lost action stop: ramp down with controlled deceleration
// - lost action protection: raise lost command trip
// - option port timeout indicator follows dual-port exchange timeout loss
// - option network loss indicator follows network fault loss
// - voltage input loss indicator follows voltage analog input loss
// - current input loss indicator follows current analog input loss
// - sub-board loss indicator follows sub-board voltage or encoder loss
// - keypad wire fault raised only when keypad wire fault setting selects it
// - trip cleared by reset key, reset terminal pair, or power cycle
// - snapshot of frequency, current, direction held until reset
// - reset key clearing a trip stores the record into history
// - five newest records kept, slot one newest
// - history clear command restores all five slots to defaults
// - present trip display shows active trip identity while active
// - open thermistor raises thermistor-open fault
// - fuse-open fault raised only on products above 37 kW
// - no-motor trip raised per no-motor trip settings
// - any fault switches power output off and shows on display
// - any trip reset clears automatic restart count
//
// Chosen here: the register addresses and the APB register port.
module dftm_top
   import dftm_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic reset_key_i,
   input wire logic reset_terminal_pair_i,
   input wire dftm_loss_t loss_i,
   input wire logic ntc_open_i,
   input wire logic fuse_open_i,
   input wire logic keypad_wire_open_i,
   input wire logic no_motor_i,
   input wire logic restart_try_i,
   input wire logic [11:0] out_freq_i,
   input wire logic [11:0] out_curr_i,
   input wire dftm_dir_t dir_i,
   output logic drive_enable_o,
   output logic coast_stop_o,
   output logic decel_stop_o,
   output logic option_port_timeout_indicator_o,
   output logic option_network_loss_indicator_o,
   output logic voltage_input_loss_indicator_o,
   output logic current_input_loss_indicator_o,
   output logic sub_board_input_loss_indicator_o,
   output logic [3:0] present_trip_display_o,
   output logic [3:0] restart_count_o
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NPIN = 11;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   dftm_loss_t loss_s;
   logic key_s, term_s, ntc_s, fuse_s, kpad_s, nomot_s;

   assign pin_raw = {reset_key_i, reset_terminal_pair_i, ntc_open_i, fuse_open_i,
                     keypad_wire_open_i, no_motor_i, loss_i};
   dftm_sync #(.W(NPIN)) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );
   assign {key_s, term_s, ntc_s, fuse_s, kpad_s, nomot_s} = pin_s[NPIN-1:5];
   assign loss_s = pin_s[4:0];

   // ----------------------------------------
   // configuration and command registers
   // ----------------------------------------
   logic [4:0] cfg_reg;
   dftm_lost_t lost_act;
   logic wr_en, rd_en, addr_ok;
   logic cmd_reset, cmd_clear;

   assign lost_act = dftm_lost_t'(cfg_reg[DFTM_CFG_LOST_LSB +: 2]);
   assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
   assign rd_en = psel_i && !penable_i && !pwrite_i;
   assign addr_ok = paddr_i[1:0] == 2'h0 && paddr_i <= DFTM_HIST_LAST;
   assign cmd_reset = wr_en && paddr_i == DFTM_CMD_ADDR && pwdata_i[DFTM_CMD_RESET_BIT];
   assign cmd_clear = wr_en && paddr_i == DFTM_CMD_ADDR && pwdata_i[DFTM_CMD_CLEAR_BIT];

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_reg <= DFTM_CFG_RESET;
      end else if (wr_en && paddr_i == DFTM_CFG_ADDR) begin
         cfg_reg <= pwdata_i[4:0];
      end
   end

   // ----------------------------------------
   // fault detection
   // ----------------------------------------
   logic lost_any, lost_trip, kpad_trip, fuse_trip, fault_any;
   logic [3:0] fault_id;

   assign lost_any = |loss_s;
   assign lost_trip = lost_any && lost_act == DFTM_LOST_PROT;
   assign kpad_trip = kpad_s && cfg_reg[DFTM_CFG_KPAD_BIT];
   assign fuse_trip = fuse_s && cfg_reg[DFTM_CFG_BIG_BIT];
   assign fault_any = lost_trip || ntc_s || fuse_trip || kpad_trip ||
                      (nomot_s && cfg_reg[DFTM_CFG_NOMOT_BIT]);

   always_comb begin
      fault_id = DFTM_TRIP_NONE;
      if (lost_trip) begin
         fault_id = DFTM_TRIP_LOST;
      end else if (ntc_s) begin
         fault_id = DFTM_TRIP_NTC;
      end else if (fuse_trip) begin
         fault_id = DFTM_TRIP_FUSE;
      end else if (nomot_s && cfg_reg[DFTM_CFG_NOMOT_BIT]) begin
         fault_id = DFTM_TRIP_NOMOT;
      end else if (kpad_trip) begin
         fault_id = DFTM_TRIP_KPAD;
      end
   end

   // ----------------------------------------
   // trip state machine
   // ----------------------------------------
   dftm_state_t state_reg;
   dftm_state_t state_next;
   logic key_d_reg, term_d_reg;
   logic key_rise, term_rise, clr_req, key_clr;
   dftm_rec_t snap_reg;

   assign key_rise = key_s && !key_d_reg;
   assign term_rise = term_s && !term_d_reg;
   assign key_clr = key_rise || cmd_reset;
   assign clr_req = key_clr || term_rise;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         key_d_reg <= 1'b0;
         term_d_reg <= 1'b0;
      end else begin
         key_d_reg <= key_s;
         term_d_reg <= term_s;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DFTM_RUN: begin
            if (fault_any) begin
               state_next = DFTM_TRIP;
            end
         end
         DFTM_TRIP: begin
            if (key_clr) begin
               state_next = DFTM_SAVE;
            end else if (term_rise) begin
               state_next = DFTM_RUN;
            end
         end
         DFTM_SAVE: begin
            state_next = DFTM_RUN;
         end
         default: begin
            state_next = DFTM_RUN;
         end
      endcase
   end

   // power cycle is the asynchronous reset, which also clears the trip
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= DFTM_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // snapshot taken on trip entry, frozen until reset
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         snap_reg <= '0;
      end else if (state_reg == DFTM_RUN && fault_any) begin
         snap_reg <= {fault_id, dir_i, 2'h0, out_freq_i, out_curr_i};
      end
   end

   // ----------------------------------------
   // drive outputs and indicators
   // ----------------------------------------
   logic trip_now;
   assign trip_now = state_next != DFTM_RUN;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         drive_enable_o <= 1'b0;
         coast_stop_o <= 1'b0;
         decel_stop_o <= 1'b0;
         present_trip_display_o <= DFTM_TRIP_NONE;
      end else begin
         drive_enable_o <= !trip_now && !(lost_any && lost_act == DFTM_LOST_FREE);
         coast_stop_o <= trip_now || (lost_any && lost_act == DFTM_LOST_FREE);
         decel_stop_o <= !trip_now && lost_any && lost_act == DFTM_LOST_STOP;
         // lost action none leaves the drive running untouched
         if (state_reg == DFTM_RUN && fault_any) begin
            present_trip_display_o <= fault_id;
         end else if (!trip_now) begin
            present_trip_display_o <= DFTM_TRIP_NONE;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         option_port_timeout_indicator_o <= 1'b0;
         option_network_loss_indicator_o <= 1'b0;
         voltage_input_loss_indicator_o <= 1'b0;
         current_input_loss_indicator_o <= 1'b0;
         sub_board_input_loss_indicator_o <= 1'b0;
      end else begin
         option_port_timeout_indicator_o <= loss_s.option_port;
         option_network_loss_indicator_o <= loss_s.network;
         voltage_input_loss_indicator_o <= loss_s.voltage;
         current_input_loss_indicator_o <= loss_s.current;
         sub_board_input_loss_indicator_o <= loss_s.sub_board;
      end
   end

   // restart attempts saturate; a trip reset wins over a new attempt
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         restart_count_o <= 4'h0;
      end else if (state_reg == DFTM_TRIP && clr_req) begin
         restart_count_o <= 4'h0;
      end else if (restart_try_i && restart_count_o != 4'hF) begin
         restart_count_o <= restart_count_o + 4'h1;
      end
   end

   // ----------------------------------------
   // trip history
   // ----------------------------------------
   logic [31:0] hist_rd;
   logic [2:0] hist_idx;
   logic [11:0] hist_off;
   assign hist_off = paddr_i - DFTM_HIST_BASE;
   assign hist_idx = hist_off[4:2];

   dftm_hist u_hist (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .store_i(state_reg == DFTM_SAVE),
      .clear_i(cmd_clear),
      .rec_i(snap_reg),
      .rd_idx_i(hist_idx),
      .rd_data_o(hist_rd)
   );

   // ----------------------------------------
   // apb slave: one wait state on reads for the history ram
   // ----------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         DFTM_CFG_ADDR: rd_mux = {27'h0, cfg_reg};
         DFTM_STAT_ADDR: rd_mux = {24'h0, state_reg, loss_s};
         DFTM_SNAP_ADDR: rd_mux = snap_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // the slot word is registered only after setup, so ready waits one more cycle
   logic hist_acc, ready_next;
   assign hist_acc = !pwrite_i && paddr_i >= DFTM_HIST_BASE;
   assign ready_next = !pready_o && psel_i && (hist_acc ? penable_i : !penable_i);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= ready_next;
         pslverr_o <= ready_next && !addr_ok;
         if (rd_en) begin
            prdata_o <= (paddr_i >= DFTM_HIST_BASE) ? 32'h0000_0000 : rd_mux;
         end else if (psel_i && penable_i && hist_acc) begin
            prdata_o <= addr_ok ? hist_rd : 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_trip_entry;
      state_reg == DFTM_RUN && fault_any;
   endsequence
   sequence s_key_save;
      state_reg == DFTM_TRIP && key_clr ##1 state_reg == DFTM_SAVE;
   endsequence

   a_fault_drive_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_trip_entry |=> !drive_enable_o && present_trip_display_o == $past(fault_id))
      else $error("drive not cut on fault");
   a_lost_prot_trip: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_RUN && lost_any && lost_act == DFTM_LOST_PROT |=> state_reg == DFTM_TRIP)
      else $error("lost command did not trip");
   a_lost_none_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_RUN && !fault_any && lost_act == DFTM_LOST_NONE |=> drive_enable_o)
      else $error("drive stopped with action none");
   a_lost_coast: assert property (@(posedge clk_i) disable iff (!nrst_i)
      lost_any && lost_act == DFTM_LOST_FREE |=> coast_stop_o && !drive_enable_o)
      else $error("free-run did not coast");
   a_lost_decel: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_RUN && !fault_any && lost_any && lost_act == DFTM_LOST_STOP
      |=> decel_stop_o)
      else $error("stop action did not decelerate");
   a_key_store: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_key_save |=> state_reg == DFTM_RUN)
      else $error("key reset did not store and return");
   a_snap_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_TRIP ##1 state_reg == DFTM_TRIP |-> $stable(snap_reg))
      else $error("snapshot changed during trip");
   a_kpad_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !cfg_reg[DFTM_CFG_KPAD_BIT] |-> fault_id != DFTM_TRIP_KPAD)
      else $error("keypad fault without setting");
   a_restart_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_TRIP && clr_req |=> restart_count_o == 4'h0)
      else $error("restart count not cleared");
   a_loss_ind: assert property (@(posedge clk_i) disable iff (!nrst_i)
      loss_s.voltage |=> voltage_input_loss_indicator_o)
      else $error("voltage loss indicator missing");
   a_term_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_reg == DFTM_TRIP && term_rise && !key_clr |=> state_reg == DFTM_RUN)
      else $error("terminal reset did not clear trip");
endmodule

// ### verilog/dftm_pkg.sv
// package: register map, field layouts, trip codes and states of the trip manager
package dftm_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [11:0] DFTM_CFG_ADDR = 12'h000;
   localparam logic [11:0] DFTM_STAT_ADDR = 12'h004;
   localparam logic [11:0] DFTM_CMD_ADDR = 12'h008;
   localparam logic [11:0] DFTM_SNAP_ADDR = 12'h00C;
   localparam logic [11:0] DFTM_HIST_BASE = 12'h010;
   localparam logic [11:0] DFTM_HIST_LAST = 12'h020;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int DFTM_CFG_LOST_LSB = 0;
   localparam int DFTM_CFG_KPAD_BIT = 2;
   localparam int DFTM_CFG_BIG_BIT = 3;
   localparam int DFTM_CFG_NOMOT_BIT = 4;
   localparam int DFTM_CMD_RESET_BIT = 0;
   localparam int DFTM_CMD_CLEAR_BIT = 1;

   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam logic [4:0] DFTM_CFG_RESET = 5'h00;
   localparam int DFTM_HIST_DEPTH = 5;
   localparam logic [31:0] DFTM_HIST_DEFAULT = 32'h0000_0000;

   // ----------------------------------------
   // lost command actions
   // ----------------------------------------
   typedef enum logic [1:0] {
      DFTM_LOST_NONE = 2'h0,
      DFTM_LOST_FREE = 2'h1,
      DFTM_LOST_STOP = 2'h2,
      DFTM_LOST_PROT = 2'h3
   } dftm_lost_t;

   // ----------------------------------------
   // trip identity codes shown on the present trip display
   // ----------------------------------------
   localparam logic [3:0] DFTM_TRIP_NONE = 4'h0;
   localparam logic [3:0] DFTM_TRIP_LOST = 4'h1;
   localparam logic [3:0] DFTM_TRIP_NTC = 4'h2;
   localparam logic [3:0] DFTM_TRIP_FUSE = 4'h3;
   localparam logic [3:0] DFTM_TRIP_NOMOT = 4'h4;
   localparam logic [3:0] DFTM_TRIP_KPAD = 4'h5;

   typedef enum logic [1:0] {
      DFTM_DIR_CONST = 2'h0,
      DFTM_DIR_ACC = 2'h1,
      DFTM_DIR_DEC = 2'h2
   } dftm_dir_t;

   // snapshot and history record
   typedef struct packed {
      logic [3:0] trip_id;
      logic [1:0] dir;
      logic [1:0] spare;
      logic [11:0] freq;
      logic [11:0] curr;
   } dftm_rec_t;

   // loss sources in indicator order
   typedef struct packed {
      logic sub_board;
      logic current;
      logic voltage;
      logic network;
      logic option_port;
   } dftm_loss_t;

   typedef enum logic [2:0] {
      DFTM_RUN = 3'b001,
      DFTM_TRIP = 3'b010,
      DFTM_SAVE = 3'b100
   } dftm_state_t;

endpackage

// ### verilog/dftm_sync.sv
// two-flop synchroniser for a group of pin levels
module dftm_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

// ### verilog/dftm_hist.sv
// five-slot trip history, shifting on store, registered read
module dftm_hist
   import dftm_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic store_i,
   input wire logic clear_i,
   input wire dftm_rec_t rec_i,
   input wire logic [2:0] rd_idx_i,
   output logic [31:0] rd_data_o
);
   dftm_rec_t slot_reg [DFTM_HIST_DEPTH];

   // ----------------------------------------
   // slots, slot 0 newest
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < DFTM_HIST_DEPTH; g++) begin : g_slot
         // head and tail split so no slot ever indexes below zero
         if (g == 0) begin : g_head
            always_ff @(posedge clk_i or negedge nrst_i) begin
               if (!nrst_i) begin
                  slot_reg[g] <= DFTM_HIST_DEFAULT;
               end else if (clear_i) begin
                  slot_reg[g] <= DFTM_HIST_DEFAULT;
               end else if (store_i) begin
                  slot_reg[g] <= rec_i;
               end
            end
         end else begin : g_tail
            always_ff @(posedge clk_i or negedge nrst_i) begin
               if (!nrst_i) begin
                  slot_reg[g] <= DFTM_HIST_DEFAULT;
               end else if (clear_i) begin
                  slot_reg[g] <= DFTM_HIST_DEFAULT;
               end else if (store_i) begin
                  slot_reg[g] <= slot_reg[g-1];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_data_o <= '0;
      end else if (rd_idx_i < 3'(DFTM_HIST_DEPTH)) begin
         rd_data_o <= slot_reg[rd_idx_i];
      end else begin
         rd_data_o <= '0;
      end
   end

   a_hist_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
      store_i && !clear_i |=> slot_reg[1] == $past(slot_reg[0]))
      else $error("history did not shift");
   a_hist_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      clear_i |=> slot_reg[4] == DFTM_HIST_DEFAULT && slot_reg[0] == DFTM_HIST_DEFAULT)
      else $error("history not cleared");
endmodule

// ### dv/dftm_far_model.sv
// far-side model: keypad reset key, reset terminal pair and reference sources
module dftm_far_model
   import dftm_pkg::*;
#(
   parameter int PRESS_LEN = 4
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic key_req_i,
   input wire logic term_req_i,
   input wire logic wire_req_i,
   input wire dftm_loss_t loss_req_i,
   output logic reset_key_o,
   output logic reset_terminal_pair_o,
   output logic keypad_wire_open_o,
   output dftm_loss_t loss_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int key_cnt;
   int term_cnt;
   // ----------------------------------------
   // contacts
   // ----------------------------------------
   // a human press lasts several cycles, not one, so each contact is held
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) key_cnt <= 0;
      else if (key_req_i) key_cnt <= PRESS_LEN;
      else if (key_cnt > 0) key_cnt <= key_cnt - 1;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) term_cnt <= 0;
      else if (term_req_i) term_cnt <= PRESS_LEN;
      else if (term_cnt > 0) term_cnt <= term_cnt - 1;
   end
   assign reset_key_o = key_cnt > 0;
   assign reset_terminal_pair_o = term_cnt > 0;
   // ----------------------------------------
   // reference sources and keypad wire
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      loss_o <= loss_req_i;
      keypad_wire_open_o <= wire_req_i;
   end
endmodule

// ### dv/test_drive_fault_trip_manager.sv
// testbench of the trip manager: lost actions, trips, resets and history
module test_drive_fault_trip_manager
   import dftm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      dftm_lost_t act;
      logic [4:0] loss;
      logic drv;
      logic cst;
      logic dcl;
      logic [3:0] disp;
   } dftm_row_t;
   logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000, freq_i = 12'h000, curr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, err, key_pin, term_pin, wire_pin;
   logic key_req = 0, term_req = 0, wire_req = 0, ntc_i = 0, fuse_i = 0, nomot_i = 0;
   logic restart_i = 0, drv_o, cst_o, dcl_o;
   logic [4:0] ind_o;
   logic [3:0] disp_o, rcnt_o;
   dftm_loss_t loss_req = '0, loss_pin;
   dftm_dir_t dir_i = DFTM_DIR_CONST;
   int num_errors = 0, samples_checked = 0, cycles = 0;
   logic [31:0] hist_exp [6];
   logic [3:0] ids [5] = '{DFTM_TRIP_NTC, DFTM_TRIP_FUSE, DFTM_TRIP_NOMOT, DFTM_TRIP_KPAD,
      DFTM_TRIP_LOST};
   dftm_row_t rows [5] = '{
      '{DFTM_LOST_NONE, 5'h01, 1'b1, 1'b0, 1'b0, 4'h0},
      '{DFTM_LOST_FREE, 5'h02, 1'b0, 1'b1, 1'b0, 4'h0},
      '{DFTM_LOST_STOP, 5'h04, 1'b1, 1'b0, 1'b1, 4'h0},
      '{DFTM_LOST_PROT, 5'h08, 1'b0, 1'b1, 1'b0, 4'h1},
      '{DFTM_LOST_NONE, 5'h10, 1'b1, 1'b0, 1'b0, 4'h0}};

   always #5 clk_i = ~clk_i;

   dftm_far_model far (.clk_i(clk_i), .nrst_i(nrst_i), .key_req_i(key_req),
      .term_req_i(term_req), .wire_req_i(wire_req), .loss_req_i(loss_req),
      .reset_key_o(key_pin), .reset_terminal_pair_o(term_pin),
      .keypad_wire_open_o(wire_pin), .loss_o(loss_pin));
   dftm_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .reset_key_i(key_pin),
      .reset_terminal_pair_i(term_pin), .loss_i(loss_pin), .ntc_open_i(ntc_i),
      .fuse_open_i(fuse_i), .keypad_wire_open_i(wire_pin), .no_motor_i(nomot_i),
      .restart_try_i(restart_i), .out_freq_i(freq_i), .out_curr_i(curr_i), .dir_i(dir_i),
      .drive_enable_o(drv_o), .coast_stop_o(cst_o), .decel_stop_o(dcl_o),
      .option_port_timeout_indicator_o(ind_o[0]), .option_network_loss_indicator_o(ind_o[1]),
      .voltage_input_loss_indicator_o(ind_o[2]), .current_input_loss_indicator_o(ind_o[3]),
      .sub_board_input_loss_indicator_o(ind_o[4]), .present_trip_display_o(disp_o),
      .restart_count_o(rcnt_o));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      err = pslverr_o;
      rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(name, rd, exp);
   endtask
   // 0 reset key, 1 terminal pair, 2 command register, 3 power cycle
   task automatic clear_by(input int how);
      @(posedge clk_i);
      case (how)
         0: key_req <= 1'b1;
         1: term_req <= 1'b1;
         2: apb(1'b1, DFTM_CMD_ADDR, 32'h1);
         default: nrst_i <= 1'b0;
      endcase
      @(posedge clk_i);
      key_req <= 1'b0;
      term_req <= 1'b0;
      nrst_i <= 1'b1;
      tick(10);
   endtask
   // raise one fault kind for a while, then drop the pin again
   task automatic trip(input int kind, input logic [11:0] f);
      @(posedge clk_i);
      freq_i <= f;
      curr_i <= ~f;
      dir_i <= DFTM_DIR_ACC;
      {wire_req, nomot_i, fuse_i, ntc_i} <= 4'(kind < 4 ? 1 << kind : 0);
      loss_req <= kind == 4 ? 5'h08 : 5'h00;
      tick(7);
      {wire_req, nomot_i, fuse_i, ntc_i} <= 4'h0;
      loss_req <= '0;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tick(10);
      nrst_i <= 1'b1;
      tick(4);
      rd_chk("cfg reset", DFTM_CFG_ADDR, 32'h0);
      chk("drive after reset", drv_o, 1'b1);
      foreach (rows[i]) begin
         apb(1'b1, DFTM_CFG_ADDR, 32'(rows[i].act));
         loss_req <= rows[i].loss;
         tick(7);
         chk("indicators", ind_o, rows[i].loss);
         chk("drive", drv_o, rows[i].drv);
         chk("coast", cst_o, rows[i].cst);
         chk("decel", dcl_o, rows[i].dcl);
         chk("display", disp_o, rows[i].disp);
         rd_chk("status", DFTM_STAT_ADDR,
            {24'h0, (rows[i].disp != 4'h0 ? DFTM_TRIP : DFTM_RUN), rows[i].loss});
         loss_req <= '0;
         tick(6);
         clear_by(1);
      end
      // fuse and keypad wire ignored while their settings are off
      apb(1'b1, DFTM_CFG_ADDR, 32'h0);
      trip(1, 12'h010);
      trip(3, 12'h010);
      chk("gated display", disp_o, DFTM_TRIP_NONE);
      chk("gated drive", drv_o, 1'b1);
      apb(1'b1, DFTM_CFG_ADDR, 32'h1F);
      for (int k = 0; k < 6; k++) begin
         trip(k % 5, 12'h100 + 12'(k));
         hist_exp[k] = {ids[k % 5], 2'h1, 2'h0, 12'h100 + 12'(k), ~(12'h100 + 12'(k))};
         chk("trip display", disp_o, ids[k % 5]);
         chk("trip drive", drv_o, 1'b0);
         if (k == 0) begin
            freq_i <= 12'hABC;
            restart_i <= 1'b1;
            tick(1);
            restart_i <= 1'b0;
            tick(2);
            rd_chk("snapshot", DFTM_SNAP_ADDR, hist_exp[0]);
            chk("restart count", rcnt_o, 4'h1);
         end
         clear_by(k == 5 ? 2 : 0);
         chk("cleared display", disp_o, DFTM_TRIP_NONE);
         chk("cleared drive", drv_o, 1'b1);
         if (k == 0) chk("restart cleared", rcnt_o, 4'h0);
      end
      for (int i = 0; i < 5; i++)
         rd_chk("history", DFTM_HIST_BASE + 12'(4 * i), hist_exp[5 - i]);
      trip(0, 12'h222);
      clear_by(1);
      chk("terminal clear", disp_o, DFTM_TRIP_NONE);
      rd_chk("no store", DFTM_HIST_BASE, hist_exp[5]);
      apb(1'b1, DFTM_CMD_ADDR, 32'h2);
      for (int i = 0; i < 5; i++)
         rd_chk("erased", DFTM_HIST_BASE + 12'(4 * i), DFTM_HIST_DEFAULT);
      rd_chk("unmapped", 12'h024, 32'h0);
      chk("unmapped err", err, 1'b1);
      trip(0, 12'h333);
      clear_by(3);
      chk("power cycle", disp_o, DFTM_TRIP_NONE);
      rd_chk("cfg after power", DFTM_CFG_ADDR, 32'h0);
      stop_test();
   end
endmodule
